/* core/argen_pkg.sv */
package argen_pkg;

    // -------------------------------------------------------------------
    // Widths and value ranges
    // -------------------------------------------------------------------
    localparam int LVL_W      = 18;
    localparam int GAIN_W     = 10;
    localparam int RATE_W     = 14;
    localparam int OUT_W      = 16;

    localparam logic signed [LVL_W-1:0] GOAL_MIN    = -18'sd10000;
    localparam logic signed [LVL_W-1:0] GOAL_MAX    = 18'sd20000;
    localparam logic signed [LVL_W-1:0] OFFSET_MAX  = 18'sd10000;
    localparam logic [LVL_W-1:0]        MARGIN_MAX  = 18'h04e20;
    localparam logic [RATE_W-1:0]       RATE_MIN    = 14'h0001;
    localparam logic [RATE_W-1:0]       RATE_MAX    = 14'h2710;
    localparam logic [GAIN_W-1:0]       GAIN_MAX    = 10'h3e8;
    localparam int                      GAIN_SCALE  = 100;
    localparam int                      OUT_MAX     = 32767;
    localparam int                      RATE_DIV    = 10;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int UPDATE_MS      = 100;
    localparam int CLK_KHZ        = 250000;
    localparam int UPDATE_CYCLES  = UPDATE_MS * CLK_KHZ;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [LVL_W-1:0] LEVEL_RST = 18'h00000;
    localparam logic [OUT_W-1:0] OUT_RST   = 16'h0000;

    typedef enum logic [2:0] {
        ARGEN_IDLE,
        ARGEN_LAUNCH,
        ARGEN_RUN,
        ARGEN_STOP_RAMP,
        ARGEN_STOP_HOLD,
        ARGEN_LOCKED
    } argen_state_t;

endpackage : argen_pkg

/* core/argen_tick.sv */
`timescale 1ns/1ps
module argen_tick
    import argen_pkg::*;
#(
    parameter int PERIOD = UPDATE_CYCLES
)(
    input  wire logic clk,
    input  wire logic rstn,
    output logic      tick
);
    initial
    begin
        if (PERIOD < 2)
            $error("argen_tick: PERIOD must be at least 2");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } argen_tick_t;

    argen_tick_t s_r;
    argen_tick_t s_nxt;

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == 32'(PERIOD - 1))
        begin
            s_nxt.cnt  = 32'h0;
            s_nxt.tick = 1'b1;
        end
        else
            s_nxt.cnt = s_r.cnt + 32'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick = s_r.tick;

endmodule : argen_tick

/* core/argen_ramp.sv */
`timescale 1ns/1ps
module argen_ramp
    import argen_pkg::*;
#(
    parameter int TICK_CYCLES = UPDATE_CYCLES
)(
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     enable,
    input  wire logic                     target_chooser,
    input  wire logic                     decel_halt,
    input  wire logic signed [LVL_W-1:0]  goal_one,
    input  wire logic signed [LVL_W-1:0]  goal_two,
    input  wire logic signed [LVL_W-1:0]  level_ceiling,
    input  wire logic signed [LVL_W-1:0]  offset,
    input  wire logic        [LVL_W-1:0]  launch_margin,
    input  wire logic        [RATE_W-1:0] rate,
    input  wire logic        [GAIN_W-1:0] gain,
    output logic signed      [LVL_W-1:0]  current_level,
    output logic             [OUT_W-1:0]  ramp_output,
    output logic                          stop_locked
);
    initial
    begin
        if (TICK_CYCLES < 2)
            $error("argen_ramp: TICK_CYCLES must be at least 2");
    end

    // -------------------------------------------------------------------
    // Update tick
    // -------------------------------------------------------------------
    logic tick;

    argen_tick #(
        .PERIOD (TICK_CYCLES)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        argen_state_t             st;
        logic signed [LVL_W-1:0]  level;
        logic [OUT_W-1:0]         out;
        logic                     armed;
        logic                     halt_q;
        logic                     locked;
    } argen_ramp_t;

    argen_ramp_t s_r;
    argen_ramp_t s_nxt;

    // Clamp inputs to documented ranges so out-of-range drive cannot overflow
    function automatic logic signed [LVL_W-1:0] clip(
        input logic signed [LVL_W-1:0] v,
        input logic signed [LVL_W-1:0] lo,
        input logic signed [LVL_W-1:0] hi
    );
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clip

    // Move one step toward target, landing exactly on it
    function automatic logic signed [LVL_W-1:0] toward(
        input logic signed [LVL_W-1:0] cur,
        input logic signed [LVL_W-1:0] tgt,
        input logic signed [LVL_W-1:0] step
    );
        if (cur < tgt)
            toward = (tgt - cur <= step) ? tgt : cur + step;
        else
            toward = (cur - tgt <= step) ? tgt : cur - step;
    endfunction : toward

    logic signed [LVL_W-1:0] goal_sel;
    logic signed [LVL_W-1:0] off_c;
    logic signed [LVL_W-1:0] ceil_c;
    logic signed [LVL_W-1:0] launch_lvl;
    logic signed [LVL_W-1:0] park_lvl;
    logic signed [LVL_W-1:0] step;
    logic signed [LVL_W-1:0] goal_c;
    logic        [RATE_W-1:0] rate_c;
    logic                    halt_rise;
    logic signed [31:0]      diff;
    logic signed [31:0]      quot;

    always_comb
    begin
        off_c      = clip(offset, -OFFSET_MAX, OFFSET_MAX);
        ceil_c     = clip(level_ceiling, GOAL_MIN, GOAL_MAX);
        goal_sel   = target_chooser ? goal_two : goal_one;
        goal_c     = clip(goal_sel, GOAL_MIN, GOAL_MAX);
        if (goal_c > ceil_c)
            goal_c = ceil_c;
        launch_lvl = off_c + $signed((launch_margin > MARGIN_MAX) ?
                     MARGIN_MAX : launch_margin);
        // Stop target kept under the ceiling, else the stop ramp never ends
        park_lvl   = (launch_lvl > ceil_c) ? ceil_c : launch_lvl;
        rate_c     = (rate < RATE_MIN) ? RATE_MIN :
                     ((rate > RATE_MAX) ? RATE_MAX : rate);
        // Slow rates still move one unit per update instead of stalling
        step       = $signed(LVL_W'(rate_c / RATE_W'(RATE_DIV)));
        if (step < 18'sd1)
            step = 18'sd1;
        halt_rise  = decel_halt && !s_r.halt_q;

        s_nxt = s_r;
        if (!enable)
            s_nxt.armed = 1'b1;

        if (!enable)
        begin
            // Acts every cycle, not only on the tick
            s_nxt.st     = ARGEN_IDLE;
            s_nxt.level  = off_c;
            s_nxt.locked = 1'b0;
        end
        else if (tick)
        begin
            s_nxt.halt_q = decel_halt;
            case (s_r.st)
                ARGEN_IDLE:
                begin
                    // Edge seen as armed-by-low; also keeps a held halt from restarting
                    if (s_r.armed && !decel_halt)
                    begin
                        s_nxt.armed = 1'b0;
                        s_nxt.level = launch_lvl;
                        s_nxt.st    = ARGEN_LAUNCH;
                    end
                end
                ARGEN_LAUNCH:
                begin
                    // One interval at launch level, then the first step at once
                    s_nxt.st    = ARGEN_RUN;
                    s_nxt.level = toward(s_r.level, goal_c, step);
                end
                ARGEN_RUN:
                begin
                    if (halt_rise)
                        s_nxt.st = ARGEN_STOP_RAMP;
                    else
                        s_nxt.level = toward(s_r.level, goal_c, step);
                end
                ARGEN_STOP_RAMP:
                begin
                    s_nxt.level = toward(s_r.level, park_lvl, step);
                    if (s_nxt.level == park_lvl)
                        s_nxt.st = ARGEN_STOP_HOLD;
                end
                ARGEN_STOP_HOLD:
                begin
                    s_nxt.level  = off_c;
                    s_nxt.st     = ARGEN_LOCKED;
                    s_nxt.locked = 1'b1;
                end
                ARGEN_LOCKED:
                    s_nxt.st = ARGEN_LOCKED;
                default:
                    s_nxt.st = ARGEN_IDLE;
            endcase
            if (s_nxt.level > ceil_c)
                s_nxt.level = ceil_c;
        end

        // Scaled output, gain in hundredths; zero gain reads as zero output
        diff = 32'(s_r.level) - 32'(off_c);
        if (diff <= 0 || gain == '0)
            quot = 0;
        else
            quot = (diff * GAIN_SCALE) / $signed({22'h0, gain});
        s_nxt.out = (quot > OUT_MAX) ? OUT_W'(OUT_MAX) : OUT_W'(quot);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_r        <= '0;
            s_r.st     <= ARGEN_IDLE;
            s_r.level  <= LEVEL_RST;
            s_r.out    <= OUT_RST;
        end
        else
            s_r <= s_nxt;
    end

    assign current_level = s_r.level;
    assign ramp_output   = s_r.out;
    assign stop_locked   = s_r.locked;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_disable_offset: assert property (@(posedge clk) disable iff (!rstn)
        !enable && $stable(offset) |=> current_level == $past(off_c))
        else $error("level not at offset after disable");

    a_launch_hold: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_LAUNCH && enable && !tick |=> s_r.st == ARGEN_LAUNCH)
        else $error("launch hold left early");

    a_launch_level: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_IDLE && enable && tick && s_r.armed && !decel_halt
        |=> s_r.st == ARGEN_LAUNCH && current_level == $past(park_lvl))
        else $error("launch level wrong");

    a_update_tick: assert property (@(posedge clk) disable iff (!rstn)
        enable && !tick |=> $stable(current_level))
        else $error("level moved between updates");

    a_step_bound: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_RUN && enable && tick && !halt_rise && s_r.level <= ceil_c
        |=> (current_level - $past(current_level) <= $past(step)) &&
            ($past(current_level) - current_level <= $past(step)))
        else $error("ramp step too large");

    a_ceiling: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_RUN && enable && tick |=> current_level <= $past(ceil_c))
        else $error("level above ceiling");

    a_halt_stop: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_RUN && enable && tick && halt_rise
        |=> s_r.st == ARGEN_STOP_RAMP)
        else $error("halt edge ignored");

    a_stop_end: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_STOP_HOLD && enable && tick
        |=> current_level == $past(off_c) && stop_locked)
        else $error("stop hold did not end at offset");

    a_no_restart: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == ARGEN_LOCKED && enable |=> s_r.st == ARGEN_LOCKED)
        else $error("restart while locked");

    a_out_range: assert property (@(posedge clk) disable iff (!rstn)
        ramp_output[OUT_W-1] == 1'b0)
        else $error("output above range");

    a_out_floor: assert property (@(posedge clk) disable iff (!rstn)
        current_level <= off_c |=> ramp_output == '0)
        else $error("output not zero at or below offset");

endmodule : argen_ramp

/* tb/argen_feed.sv */
`timescale 1ns/1ps
module argen_feed
    import argen_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic signed [LVL_W-1:0] want_one,
    input  wire logic signed [LVL_W-1:0] want_two,
    output logic signed      [LVL_W-1:0] goal_one,
    output logic signed      [LVL_W-1:0] goal_two
);
    initial
    begin
        goal_one = '0;
        goal_two = '0;
    end

    // Upstream blocks publish off the sampling edge
    always @(negedge clk)
    begin
        goal_one <= want_one;
        goal_two <= want_two;
    end
endmodule : argen_feed

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import argen_pkg::*;
;
    logic                      clk, rstn, enable, target_chooser, decel_halt, stop_locked;
    logic signed [LVL_W-1:0]   want_one, want_two, goal_one, goal_two;
    logic signed [LVL_W-1:0]   level_ceiling, offset, current_level;
    logic        [LVL_W-1:0]   launch_margin;
    logic        [RATE_W-1:0]  rate;
    logic        [GAIN_W-1:0]  gain;
    logic        [OUT_W-1:0]   ramp_output;
    int                        num_errors = 0;
    int                        cmp_count  = 0;

    argen_feed feed (.clk(clk), .want_one(want_one), .want_two(want_two),
                     .goal_one(goal_one), .goal_two(goal_two));

    // Short tick keeps each 100 ms step to 8 cycles
    argen_ramp #(.TICK_CYCLES(8)) dut (
        .clk(clk), .rstn(rstn), .enable(enable), .target_chooser(target_chooser),
        .decel_halt(decel_halt), .goal_one(goal_one), .goal_two(goal_two),
        .level_ceiling(level_ceiling), .offset(offset), .launch_margin(launch_margin),
        .rate(rate), .gain(gain), .current_level(current_level),
        .ramp_output(ramp_output), .stop_locked(stop_locked));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [LVL_W-1:0] exp,
                       input logic [LVL_W-1:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", name, $signed(exp), $signed(got));
        end
    endtask : chk

    // Counts falling edges until the level moves; bounded
    task automatic wait_move(output int n);
        logic signed [LVL_W-1:0] prev;
        prev = current_level;
        n = 0;
        while (current_level === prev && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 100)
        begin
            num_errors++;
            $display("wrong value level move expected change seen none");
            report_and_stop();
        end
    endtask : wait_move

    task automatic quiet(input int cyc);
        logic signed [LVL_W-1:0] prev;
        prev = current_level;
        repeat (cyc) @(negedge clk);
        chk("steady level", prev, current_level);
    endtask : quiet

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_launch();
        int n;
        enable = 1'b1;
        wait_move(n);
        chk("launch level", 18'd150, current_level);
        wait_move(n);
        chk("launch hold", 18'd8, n[LVL_W-1:0]);
        chk("first step", 18'd160, current_level);
        @(negedge clk);
        chk("scaled out", 18'd60, {2'b00, ramp_output});
        repeat (4) wait_move(n);
        chk("goal one", 18'd200, current_level);
        quiet(40);
        $display("test launch done");
    endtask : t_launch

    task automatic t_switch();
        int n;
        target_chooser = 1'b1;
        wait_move(n);
        chk("switch step", 18'd190, current_level);
        wait_move(n);
        chk("goal two", 18'd180, current_level);
        quiet(40);
        $display("test switch done");
    endtask : t_switch

    task automatic t_stop();
        int n;
        decel_halt = 1'b1;
        wait_move(n);
        chk("stop step", 18'd170, current_level);
        wait_move(n);
        wait_move(n);
        chk("stop level", 18'd150, current_level);
        wait_move(n);
        chk("stop hold", 18'd8, n[LVL_W-1:0]);
        chk("offset level", 18'd100, current_level);
        @(negedge clk);
        chk("stop out", 18'd0, {2'b00, ramp_output});
        chk("locked", 18'd1, {17'd0, stop_locked});
        decel_halt = 1'b0;
        quiet(40);
        enable = 1'b0;
        repeat (2) @(negedge clk);
        chk("unlocked", 18'd0, {17'd0, stop_locked});
        $display("test stop done");
    endtask : t_stop

    task automatic t_clamp();
        int n;
        level_ceiling  = 18'sd170;
        rate           = 14'h012c;
        gain           = 10'h032;
        target_chooser = 1'b0;
        enable         = 1'b1;
        wait_move(n);
        chk("relaunch", 18'd150, current_level);
        wait_move(n);
        chk("ceiling", 18'd170, current_level);
        @(negedge clk);
        chk("gain out", 18'd140, {2'b00, ramp_output});
        quiet(40);
        // Drop mid-run: no ramp down expected
        enable = 1'b0;
        repeat (2) @(negedge clk);
        chk("disable level", 18'd100, current_level);
        @(negedge clk);
        chk("disable out", 18'd0, {2'b00, ramp_output});
        $display("test clamp done");
    endtask : t_clamp

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        rstn = 1'b0;
        enable = 1'b0;
        target_chooser = 1'b0;
        decel_halt = 1'b0;
        want_one = 18'sd200;
        want_two = 18'sd180;
        level_ceiling = 18'sd20000;
        offset = 18'sd100;
        launch_margin = 18'h00032;
        rate = 14'h0064;
        gain = 10'h064;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        t_launch();
        t_switch();
        t_stop();
        t_clamp();
        report_and_stop();
    end
endmodule : tb_top
